// file: lts_pkg.sv
// Constants, field layout and encodings of the link training status registers.
package lts_pkg;

    // Register byte offsets on the APB.
    localparam int ADDR_W = 12;
    localparam logic [11:0] OFS_COMPLIANCE = 12'h068;
    localparam logic [11:0] OFS_ENTRY_BLOCK = 12'h06c;
    localparam logic [11:0] OFS_LINK_STATUS = 12'h080;
    localparam logic [11:0] OFS_TRAINING = 12'h084;
    localparam logic [11:0] OFS_RX_LOW_POWER = 12'h088;
    localparam logic [11:0] OFS_REASONS = 12'h08c;
    localparam logic [11:0] OFS_LANES = 12'h090;

    // Compliance rate range fields and reset values.
    localparam int MAX_SPEED_LO = 2;
    localparam int MIN_SPEED_LO = 0;
    localparam logic [1:0] MAX_SPEED_RST = 2'h3;
    localparam logic [1:0] MIN_SPEED_RST = 2'h0;
    localparam logic [1:0] RATE_2G5 = 2'h0;
    localparam logic [1:0] RATE_5G = 2'h1;

    // Received-training-set entry disables, also the grant vector order.
    localparam int BLK_DISABLE = 0;
    localparam int BLK_HOT_RESET = 1;
    localparam int BLK_LOOPBACK = 2;
    localparam int BLK_COMPLIANCE = 3;
    localparam logic [3:0] BLOCK_RST = 4'h0;

    // Link status bits.
    localparam int LINK_LAYER_BIT = 31;
    localparam int PHYS_LAYER_BIT = 30;
    localparam int IDLE_INFER_LO = 11;
    localparam int SPEED_FAIL_BIT = 8;
    localparam logic [15:0] LINK_FLAG_MASK = 16'hf900;

    // Training state view fields and reset values.
    localparam int MINOR_LO = 16;
    localparam logic [3:0] MAJOR_RST = 4'h0;
    localparam logic [3:0] MINOR_RST = 4'h1;

    // Recovery entry reason bits; bit 6 is reserved.
    localparam int RSN_RETRAIN = 0;
    localparam int RSN_DISABLE = 3;
    localparam int RSN_HOT_RESET = 4;
    localparam int RSN_RETRY = 5;
    localparam int RSN_PHY_BURST = 7;
    localparam int RSN_SKIP_TIMEOUT = 8;
    localparam int RSN_EIE_8G = 9;
    localparam int RSN_PARTNER_TS = 10;
    localparam int RSN_SPEED_CHANGE = 11;
    localparam logic [15:0] REASON_MASK = 16'h7fbf;

    // Timing.
    localparam int CLK_MHZ = 200;
    localparam int SKIP_TIMEOUT_US = 128;
    localparam int SKIP_TIMEOUT_CYCLES = SKIP_TIMEOUT_US * CLK_MHZ;
    localparam int PHY_BURST_CYCLES = 1024;

    typedef enum logic [3:0] {
        MAJ_DETECT = 4'h0,
        MAJ_POLLING = 4'h1,
        MAJ_CONFIG = 4'h2,
        MAJ_L0 = 4'h3,
        MAJ_RECOVERY = 4'h4,
        MAJ_DISABLED = 4'h5,
        MAJ_LOOPBACK = 4'h6,
        MAJ_HOT_RESET = 4'h7,
        MAJ_TX_L0S = 4'h8,
        MAJ_L1 = 4'h9,
        MAJ_L2 = 4'ha
    } major_state_type;

endpackage : lts_pkg

// file: flag_bank_if.sv
// Carrier between a register owner and a bank of sticky flags.
interface flag_bank_if #(
    parameter int W = 16
);
    logic [W-1:0] set;
    logic [W-1:0] clr;
    logic [W-1:0] flags;

    modport bank (
        input set,
        input clr,
        output flags
    );
    modport owner (
        output set,
        output clr,
        input flags
    );
endinterface : flag_bank_if

// file: sticky_flags.sv
// Bank of sticky write-one-to-clear flags in which a set beats a clear.
module sticky_flags #(
    parameter int W = 16,
    parameter logic [W-1:0] MASK = '1
) (
    input wire logic clk,
    input wire logic rst_n,
    flag_bank_if.bank fb
);
    logic [W-1:0] flags_q;

    if (W < 1) begin : g_bad_width
        $error("sticky_flags needs at least one flag");
    end

    // A new event outranks a clearing write in the same cycle.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            flags_q <= '0;
        end else begin
            flags_q <= ((flags_q & ~fb.clr) | fb.set) & MASK;
        end
    end

    assign fb.flags = flags_q;

    AST_SET_WINS: assert property (
        @(posedge clk) disable iff (!rst_n)
        ((fb.set & fb.clr & MASK) != '0) |=>
            ((flags_q & $past(fb.set & fb.clr & MASK))
             == $past(fb.set & fb.clr & MASK)))
        else $error("flag lost when set and clear met");

    AST_CLEAR_TAKES: assert property (
        @(posedge clk) disable iff (!rst_n)
        ((fb.clr & ~fb.set) != '0) |=>
            ((flags_q & $past(fb.clr & ~fb.set)) == '0))
        else $error("written one did not clear flag");

    AST_HOLD: assert property (
        @(posedge clk) disable iff (!rst_n)
        (fb.clr == '0) |=> ((flags_q & $past(flags_q)) == $past(flags_q)))
        else $error("sticky flag dropped without a clear");

endmodule : sticky_flags

// file: link_training_status_regs.sv
// Link training configuration and status registers behind an APB slave.
module link_training_status_regs #(
    parameter int SKIP_TIMEOUT_CYCLES = lts_pkg::SKIP_TIMEOUT_CYCLES,
    parameter int PHY_BURST_CYCLES = lts_pkg::PHY_BURST_CYCLES,
    parameter logic [1:0] MAX_SUPPORTED_RATE = lts_pkg::RATE_5G
) (
    input wire logic clk,
    input wire logic resetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic link_layer_alive,
    input wire logic phys_layer_alive,
    input wire logic [1:0] link_speed,
    input wire logic [3:0] major_state,
    input wire logic [3:0] minor_state,
    input wire logic [2:0] rx_low_power_state,
    input wire logic [15:0] lane_presence,
    input wire logic [4:0] idle_infer_evt,
    input wire logic speed_change_fail_evt,
    input wire logic partner_training_set_reason,
    input wire logic eie_8g_reason,
    input wire logic retry_exhausted_reason,
    input wire logic [15:0] other_reason_evt,
    input wire logic skip_seen,
    input wire logic phy_error_cycle,
    input wire logic [3:0] rx_ts_entry_req,
    input wire logic [3:0] directed_entry_req,
    output logic [3:0] entry_grant,
    output logic compliance_allowed,
    output logic recovery_request
);
    localparam int SKIP_W = $clog2(SKIP_TIMEOUT_CYCLES + 1);
    localparam int PHY_W = $clog2(PHY_BURST_CYCLES + 1);
    localparam logic [SKIP_W-1:0] SKIP_LAST =
        SKIP_W'(SKIP_TIMEOUT_CYCLES - 1);
    localparam logic [PHY_W-1:0] PHY_LAST = PHY_W'(PHY_BURST_CYCLES - 1);

    if (SKIP_TIMEOUT_CYCLES < 2 || PHY_BURST_CYCLES < 2) begin : g_bad_cnt
        $error("timeout counts must be at least two cycles");
    end
    if (MAX_SUPPORTED_RATE > lts_pkg::RATE_5G) begin : g_bad_rate
        $error("only 2.5G and 5G rates are served");
    end

    logic rst_meta_q;
    logic rst_n;
    logic [1:0] max_speed_q;
    logic [1:0] min_speed_q;
    logic [3:0] block_q;
    logic link_up_q;
    logic phys_up_q;
    logic [1:0] speed_q;
    logic [3:0] major_q;
    logic [3:0] minor_q;
    logic [2:0] rx_lp_q;
    logic [15:0] lanes_q;
    logic [31:0] prdata_q;
    logic [3:0] grant_q;
    logic compliance_ok_q;
    logic [SKIP_W-1:0] skip_cnt_q;
    logic [PHY_W-1:0] phy_cnt_q;
    logic skip_timeout_reason;
    logic phy_error_burst_reason;
    logic in_l0;
    logic setup;
    logic wr_access;
    logic mapped;
    logic [31:0] wmask;

    flag_bank_if #(.W(16)) link_fb ();
    flag_bank_if #(.W(16)) reason_fb ();

    // The release of the reset is retimed; its assertion stays immediate.
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            rst_meta_q <= 1'b0;
            rst_n <= 1'b0;
        end else begin
            rst_meta_q <= 1'b1;
            rst_n <= rst_meta_q;
        end
    end

    // APB decode: zero wait states, unmapped offsets answer with an error.
    always_comb begin
        case (paddr)
            lts_pkg::OFS_COMPLIANCE,
            lts_pkg::OFS_ENTRY_BLOCK,
            lts_pkg::OFS_LINK_STATUS,
            lts_pkg::OFS_TRAINING,
            lts_pkg::OFS_RX_LOW_POWER,
            lts_pkg::OFS_REASONS,
            lts_pkg::OFS_LANES: mapped = 1'b1;
            default: mapped = 1'b0;
        endcase
    end

    assign setup = psel && !penable;
    assign wr_access = psel && penable && pwrite && mapped;
    assign wmask = {{8{pstrb[3]}}, {8{pstrb[2]}}, {8{pstrb[1]}},
                    {8{pstrb[0]}}};
    assign pready = 1'b1;
    assign pslverr = psel && penable && !mapped;
    assign prdata = prdata_q;

    // Software-owned control fields.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            max_speed_q <= lts_pkg::MAX_SPEED_RST;
            min_speed_q <= lts_pkg::MIN_SPEED_RST;
            block_q <= lts_pkg::BLOCK_RST;
        end else if (wr_access && pstrb[0]) begin
            if (paddr == lts_pkg::OFS_COMPLIANCE) begin
                max_speed_q <= pwdata[lts_pkg::MAX_SPEED_LO +: 2];
                min_speed_q <= pwdata[lts_pkg::MIN_SPEED_LO +: 2];
            end
            if (paddr == lts_pkg::OFS_ENTRY_BLOCK) begin
                block_q <= pwdata[3:0];
            end
        end
    end

    // Status snapshots; the minor state wakes up as one.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            link_up_q <= 1'b0;
            phys_up_q <= 1'b0;
            speed_q <= lts_pkg::RATE_2G5;
            major_q <= lts_pkg::MAJOR_RST;
            minor_q <= lts_pkg::MINOR_RST;
            rx_lp_q <= 3'h0;
            lanes_q <= 16'h0000;
        end else begin
            link_up_q <= link_layer_alive;
            phys_up_q <= phys_layer_alive;
            // An unsupported code is never shown; the last valid one stays.
            if (link_speed <= MAX_SUPPORTED_RATE) begin
                speed_q <= link_speed;
            end
            major_q <= major_state;
            // Meaning follows the major state.
            minor_q <= minor_state;
            rx_lp_q <= rx_low_power_state;
            lanes_q <= lane_presence;
        end
    end

    // Read data are latched in the setup cycle and stand through access.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            prdata_q <= 32'h00000000;
        end else if (setup && !pwrite) begin
            case (paddr)
                lts_pkg::OFS_COMPLIANCE:
                    prdata_q <= {28'h0000000, max_speed_q, min_speed_q};
                lts_pkg::OFS_ENTRY_BLOCK:
                    prdata_q <= {28'h0000000, block_q};
                lts_pkg::OFS_LINK_STATUS:
                    prdata_q <= {link_up_q, phys_up_q, 14'h0000,
                                 link_fb.flags[15:2], speed_q};
                lts_pkg::OFS_TRAINING:
                    prdata_q <= {12'h000, minor_q, 12'h000, major_q};
                lts_pkg::OFS_RX_LOW_POWER:
                    prdata_q <= {29'h00000000, rx_lp_q};
                lts_pkg::OFS_REASONS:
                    prdata_q <= {16'h0000, reason_fb.flags};
                lts_pkg::OFS_LANES:
                    prdata_q <= {16'h0000, lanes_q};
                default:
                    prdata_q <= 32'h00000000;
            endcase
        end
    end

    assign in_l0 = (major_state == 4'(lts_pkg::MAJ_L0));

    // Skip watchdog: restarted by every skip set and outside L0.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            skip_cnt_q <= '0;
        end else if (!in_l0 || skip_seen || skip_timeout_reason) begin
            skip_cnt_q <= '0;
        end else begin
            skip_cnt_q <= skip_cnt_q + SKIP_W'(1);
        end
    end
    assign skip_timeout_reason = in_l0 && !skip_seen &&
                                 (skip_cnt_q == SKIP_LAST);

    // Error burst: only an unbroken run at 2.5G or 5G counts.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            phy_cnt_q <= '0;
        end else if (!in_l0 || !phy_error_cycle || phy_error_burst_reason
                     || speed_q > lts_pkg::RATE_5G) begin
            phy_cnt_q <= '0;
        end else begin
            phy_cnt_q <= phy_cnt_q + PHY_W'(1);
        end
    end
    assign phy_error_burst_reason = in_l0 && phy_error_cycle &&
                                    (phy_cnt_q == PHY_LAST);

    assign recovery_request = skip_timeout_reason ||
        phy_error_burst_reason ||
        (in_l0 && retry_exhausted_reason);

    // Link status flags: hardware events set, written ones clear.
    always_comb begin
        link_fb.set = 16'h0000;
        link_fb.set[lts_pkg::IDLE_INFER_LO +: 5] = idle_infer_evt;
        link_fb.set[lts_pkg::SPEED_FAIL_BIT] = speed_change_fail_evt;
        link_fb.clr = 16'h0000;
        if (wr_access && paddr == lts_pkg::OFS_LINK_STATUS) begin
            link_fb.clr = pwdata[15:0] & wmask[15:0];
        end
    end

    // Reasons are recorded only for an exit taken from L0.
    always_comb begin
        reason_fb.set = other_reason_evt;
        reason_fb.set[lts_pkg::RSN_PARTNER_TS] = partner_training_set_reason
            || other_reason_evt[lts_pkg::RSN_PARTNER_TS];
        reason_fb.set[lts_pkg::RSN_EIE_8G] = eie_8g_reason
            || other_reason_evt[lts_pkg::RSN_EIE_8G];
        reason_fb.set[lts_pkg::RSN_SKIP_TIMEOUT] = skip_timeout_reason;
        reason_fb.set[lts_pkg::RSN_PHY_BURST] = phy_error_burst_reason;
        reason_fb.set[lts_pkg::RSN_RETRY] = retry_exhausted_reason
            || other_reason_evt[lts_pkg::RSN_RETRY];
        if (!in_l0) begin
            reason_fb.set = 16'h0000;
        end
        reason_fb.clr = 16'h0000;
        if (wr_access && paddr == lts_pkg::OFS_REASONS) begin
            reason_fb.clr = pwdata[15:0] & wmask[15:0];
        end
    end

    sticky_flags #(.W(16), .MASK(lts_pkg::LINK_FLAG_MASK)) u_link_flags (
        .clk(clk),
        .rst_n(rst_n),
        .fb(link_fb.bank)
    );

    sticky_flags #(.W(16), .MASK(lts_pkg::REASON_MASK)) u_reason_flags (
        .clk(clk),
        .rst_n(rst_n),
        .fb(reason_fb.bank)
    );

    // Software-directed entries always pass; training-set ones may be cut.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            grant_q <= 4'h0;
            compliance_ok_q <= 1'b0;
        end else begin
            grant_q <= directed_entry_req |
                       (rx_ts_entry_req & ~block_q);
            compliance_ok_q <= (speed_q >= min_speed_q) &&
                               (speed_q <= max_speed_q);
        end
    end
    assign entry_grant = grant_q;
    assign compliance_allowed = compliance_ok_q;

    AST_DIRECTED_PASSES: assert property (
        @(posedge clk) disable iff (!rst_n)
        (directed_entry_req != 4'h0) |=>
            ((entry_grant & $past(directed_entry_req))
             == $past(directed_entry_req)))
        else $error("directed entry was not granted");

    AST_RX_TS_BLOCKED: assert property (
        @(posedge clk) disable iff (!rst_n)
        ((rx_ts_entry_req & block_q & ~directed_entry_req) != 4'h0) |=>
            ((entry_grant & $past(rx_ts_entry_req & block_q
              & ~directed_entry_req)) == 4'h0))
        else $error("disabled training-set entry was granted");

    AST_COMPLIANCE_RANGE: assert property (
        @(posedge clk) disable iff (!rst_n)
        compliance_allowed |-> ($past(speed_q) >= $past(min_speed_q)
            && $past(speed_q) <= $past(max_speed_q)))
        else $error("compliance allowed outside speed range");

    AST_LINK_UP_READ: assert property (
        @(posedge clk) disable iff (!rst_n)
        (setup && !pwrite && paddr == lts_pkg::OFS_LINK_STATUS) |=>
            (prdata[31] == $past(link_up_q) && prdata[30] == $past(phys_up_q)))
        else $error("link up bits misreported");

    AST_SPEED_SUPPORTED: assert property (
        @(posedge clk) disable iff (!rst_n)
        speed_q <= MAX_SUPPORTED_RATE)
        else $error("unsupported speed shown");

    AST_IDLE_INFER_SET: assert property (
        @(posedge clk) disable iff (!rst_n)
        idle_infer_evt[0] |=> link_fb.flags[lts_pkg::IDLE_INFER_LO])
        else $error("idle inference flag not set");

    AST_SPEED_FAIL_SET: assert property (
        @(posedge clk) disable iff (!rst_n)
        speed_change_fail_evt |=> link_fb.flags[lts_pkg::SPEED_FAIL_BIT])
        else $error("speed change failure flag not set");

    AST_SKIP_TIMEOUT: assert property (
        @(posedge clk) disable iff (!rst_n)
        (in_l0 && !skip_seen && skip_cnt_q == SKIP_LAST) |->
            recovery_request ##1 reason_fb.flags[lts_pkg::RSN_SKIP_TIMEOUT])
        else $error("skip timeout did not force recovery");

    AST_PHY_BURST: assert property (
        @(posedge clk) disable iff (!rst_n)
        phy_error_burst_reason |->
            recovery_request ##1 reason_fb.flags[lts_pkg::RSN_PHY_BURST])
        else $error("error burst did not force recovery");

    AST_RETRY: assert property (
        @(posedge clk) disable iff (!rst_n)
        (in_l0 && retry_exhausted_reason) |->
            recovery_request ##1 reason_fb.flags[lts_pkg::RSN_RETRY])
        else $error("exhausted replays did not force recovery");

    AST_PARTNER_TS: assert property (
        @(posedge clk) disable iff (!rst_n)
        (in_l0 && partner_training_set_reason) |=>
            reason_fb.flags[lts_pkg::RSN_PARTNER_TS])
        else $error("partner training set reason not set");

    AST_SPEED_CHANGE: assert property (
        @(posedge clk) disable iff (!rst_n)
        (in_l0 && other_reason_evt[lts_pkg::RSN_SPEED_CHANGE]) |=>
            reason_fb.flags[lts_pkg::RSN_SPEED_CHANGE])
        else $error("directed speed change reason not set");

    AST_DIRECTED_REASONS: assert property (
        @(posedge clk) disable iff (!rst_n)
        (in_l0 && other_reason_evt[lts_pkg::RSN_HOT_RESET]
         && other_reason_evt[lts_pkg::RSN_DISABLE]) |=>
            (reason_fb.flags[lts_pkg::RSN_HOT_RESET]
             && reason_fb.flags[lts_pkg::RSN_DISABLE]))
        else $error("directed reason flags not set");

endmodule : link_training_status_regs

// file: lts_link_partner.sv
// Far-side stand-in that delivers skip ordered sets at a programmable gap.
module lts_link_partner (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [7:0] gap,
    output logic skip_seen
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] cnt_q;
    // A gap of zero models a partner that has gone silent on the lane.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_q <= 8'h00;
        end else if (gap == 8'h00 || cnt_q >= gap - 8'h01) begin
            cnt_q <= 8'h00;
        end else begin
            cnt_q <= cnt_q + 8'h01;
        end
    end
    assign skip_seen = (gap != 8'h00) && (cnt_q == gap - 8'h01);
endmodule : lts_link_partner

// file: tb.sv
// Self-checking bench for the link training status registers.
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int SKIP_CYC = 16;
    localparam int BURST_CYC = 8;
    logic clk, resetn, psel, penable, pwrite, pready, pslverr, err_q;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd_q;
    logic [3:0] pstrb, major_state, minor_state, rx_ts_entry_req;
    logic [3:0] directed_entry_req, entry_grant;
    logic link_layer_alive, phys_layer_alive, speed_change_fail_evt;
    logic partner_training_set_reason, eie_8g_reason;
    logic retry_exhausted_reason, skip_seen, phy_error_cycle;
    logic compliance_allowed, recovery_request;
    logic [1:0] link_speed;
    logic [2:0] rx_low_power_state;
    logic [15:0] lane_presence, other_reason_evt;
    logic [4:0] idle_infer_evt;
    logic [7:0] skip_gap;
    int num_errors, total_checks, cycles, req_cnt;

    link_training_status_regs #(.SKIP_TIMEOUT_CYCLES(SKIP_CYC),
        .PHY_BURST_CYCLES(BURST_CYC)) i_link_training_status_regs (
        .clk, .resetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb,
        .prdata, .pready, .pslverr, .link_layer_alive, .phys_layer_alive,
        .link_speed, .major_state, .minor_state, .rx_low_power_state,
        .lane_presence, .idle_infer_evt, .speed_change_fail_evt,
        .partner_training_set_reason, .eie_8g_reason,
        .retry_exhausted_reason, .other_reason_evt, .skip_seen,
        .phy_error_cycle, .rx_ts_entry_req, .directed_entry_req,
        .entry_grant, .compliance_allowed, .recovery_request);
    lts_link_partner i_lts_link_partner (.clk, .rst_n(resetn),
        .gap(skip_gap), .skip_seen);

    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    // Requests are counted at the edge so a one-cycle pulse is never missed.
    always @(posedge clk) begin
        cycles++;
        if (recovery_request === 1'b1) req_cnt++;
        if (cycles == 20000) begin
            num_errors++;
            results();
        end
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task automatic apb(input logic w, input logic [11:0] a,
                       input logic [31:0] d);
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        rd_q = prdata;
        err_q = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task automatic rd(input logic [11:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        chk(rd_q, exp);
    endtask : rd
    task automatic t_reset();
        rd(lts_pkg::OFS_COMPLIANCE, 32'hc);
        rd(lts_pkg::OFS_ENTRY_BLOCK, 32'h0);
        rd(lts_pkg::OFS_LINK_STATUS, 32'h0);
        rd(lts_pkg::OFS_TRAINING, 32'h00010000);
        rd(lts_pkg::OFS_RX_LOW_POWER, 32'h0);
        rd(lts_pkg::OFS_REASONS, 32'h0);
        rd(12'h070, 32'h0);
        chk({31'h0, err_q}, 32'h1);
    endtask : t_reset
    task automatic t_compliance();
        apb(1'b1, lts_pkg::OFS_COMPLIANCE, 32'h5);
        pstrb <= 4'h0;
        apb(1'b1, lts_pkg::OFS_COMPLIANCE, 32'h0);
        pstrb <= 4'hf;
        rd(lts_pkg::OFS_COMPLIANCE, 32'h5);
        for (int s = 0; s < 2; s++) begin
            @(posedge clk);
            link_speed <= s[1:0];
            repeat (3) @(posedge clk);
            #1 chk({31'h0, compliance_allowed}, s);
        end
    endtask : t_compliance
    task automatic t_entry();
        // Hot reset and compliance entries stay enabled for their users.
        apb(1'b1, lts_pkg::OFS_ENTRY_BLOCK, 32'h5);
        rx_ts_entry_req <= 4'hf;
        repeat (2) @(posedge clk);
        #1 chk({28'h0, entry_grant}, 32'ha);
        @(posedge clk);
        directed_entry_req <= 4'h5;
        repeat (2) @(posedge clk);
        #1 chk({28'h0, entry_grant}, 32'hf);
        @(posedge clk);
        rx_ts_entry_req <= 4'h0;
        directed_entry_req <= 4'h0;
    endtask : t_entry
    task automatic t_status();
        link_layer_alive <= 1'b1;
        lane_presence <= 16'ha5c3;
        rd(lts_pkg::OFS_LINK_STATUS, 32'h80000001);
        link_speed <= 2'h2;
        link_layer_alive <= 1'b0;
        phys_layer_alive <= 1'b1;
        rd(lts_pkg::OFS_LINK_STATUS, 32'h40000001);
        for (int m = 0; m < 11; m++) begin
            major_state <= m[3:0];
            minor_state <= 4'ha - m[3:0];
            rd(lts_pkg::OFS_TRAINING,
               {12'h0, 4'ha - m[3:0], 12'h0, m[3:0]});
        end
        for (int s = 0; s < 5; s++) begin
            rx_low_power_state <= s[2:0];
            rd(lts_pkg::OFS_RX_LOW_POWER, s);
        end
        rd(lts_pkg::OFS_LANES, 32'ha5c3);
    endtask : t_status
    task automatic t_events();
        @(posedge clk);
        idle_infer_evt <= 5'h1f;
        speed_change_fail_evt <= 1'b1;
        @(posedge clk);
        idle_infer_evt <= 5'h00;
        speed_change_fail_evt <= 1'b0;
        rd(lts_pkg::OFS_LINK_STATUS, 32'h4000f901);
        apb(1'b1, lts_pkg::OFS_LINK_STATUS, 32'h0);
        rd(lts_pkg::OFS_LINK_STATUS, 32'h4000f901);
        apb(1'b1, lts_pkg::OFS_LINK_STATUS, 32'hf900);
        rd(lts_pkg::OFS_LINK_STATUS, 32'h40000001);
        // The event lands on the very edge that commits the clearing write.
        fork
            apb(1'b1, lts_pkg::OFS_LINK_STATUS, 32'h800);
            begin
                repeat (2) @(posedge clk);
                idle_infer_evt <= 5'h01;
                @(posedge clk);
                idle_infer_evt <= 5'h00;
            end
        join
        rd(lts_pkg::OFS_LINK_STATUS, 32'h40000801);
        apb(1'b1, lts_pkg::OFS_LINK_STATUS, 32'h800);
    endtask : t_events
    task automatic t_reasons(input logic [3:0] maj, input logic [31:0] exp);
        major_state <= maj;
        @(posedge clk);
        other_reason_evt <= 16'hffff;
        {partner_training_set_reason, eie_8g_reason} <= 2'h3;
        retry_exhausted_reason <= 1'b1;
        #1 chk({31'h0, recovery_request}, exp != 0);
        @(posedge clk);
        other_reason_evt <= 16'h0;
        {partner_training_set_reason, eie_8g_reason} <= 2'h0;
        retry_exhausted_reason <= 1'b0;
        rd(lts_pkg::OFS_REASONS, exp);
        apb(1'b1, lts_pkg::OFS_REASONS, 32'hffff);
    endtask : t_reasons
    task automatic t_skip();
        int n;
        major_state <= lts_pkg::MAJ_L0;
        skip_gap <= 8'h00;
        do @(posedge clk); while (recovery_request !== 1'b1);
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (recovery_request !== 1'b1);
        chk(n, SKIP_CYC);
        skip_gap <= 8'h08;
        rd(lts_pkg::OFS_REASONS, 32'h100);
        apb(1'b1, lts_pkg::OFS_REASONS, 32'hffff);
        n = req_cnt;
        repeat (40) @(posedge clk);
        chk(req_cnt, n);
    endtask : t_skip
    task automatic t_burst(input int len, input logic [31:0] exp);
        int n;
        n = req_cnt;
        phy_error_cycle <= 1'b1;
        repeat (len) @(posedge clk);
        phy_error_cycle <= 1'b0;
        repeat (2) @(posedge clk);
        chk(req_cnt - n, exp != 0);
        rd(lts_pkg::OFS_REASONS, exp);
        apb(1'b1, lts_pkg::OFS_REASONS, 32'hffff);
    endtask : t_burst
    task automatic results();
        $display("checks=%0d errors=%0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : results

    initial begin
        {resetn, psel, penable, pwrite, paddr, pwdata} = '0;
        {link_layer_alive, phys_layer_alive, link_speed, major_state} = '0;
        {rx_low_power_state, lane_presence, idle_infer_evt} = '0;
        {speed_change_fail_evt, partner_training_set_reason} = '0;
        {eie_8g_reason, retry_exhausted_reason, other_reason_evt} = '0;
        {phy_error_cycle, rx_ts_entry_req, directed_entry_req} = '0;
        {num_errors, total_checks, cycles, req_cnt} = '0;
        minor_state = 4'h1;
        pstrb = 4'hf;
        skip_gap = 8'h08;
        repeat (3) @(posedge clk);
        resetn <= 1'b1;
        repeat (4) @(posedge clk);
        t_reset();
        t_compliance();
        t_entry();
        t_status();
        t_events();
        // Bits 8 and 7 come only from the block's own timers, not the pulses.
        t_reasons(lts_pkg::MAJ_L0, 32'h7e3f);
        t_reasons(lts_pkg::MAJ_RECOVERY, 32'h0);
        t_skip();
        t_burst(BURST_CYC - 1, 32'h0);
        t_burst(BURST_CYC, 32'h80);
        results();
    end
endmodule : tb
